// [include/gbc_regs.svh]
`ifndef GBC_REGS_SVH
`define GBC_REGS_SVH

// Page codes of the configuration port
`define GBC_PG_GAIN_A    24'h610005
`define GBC_PG_GAIN_B    24'h610105
`define GBC_PG_MAIN_A    24'h680000
`define GBC_PG_MAIN_B    24'h680100

// Register addresses inside a page
`define GBC_ADR_RST      12'h000
`define GBC_ADR_BAND     12'h0A2
`define GBC_ADR_GAIN     12'h0A6

// Field positions and reset values
`define GBC_RST_BIT      0
`define GBC_BAND_EN_BIT  3
`define GBC_RST_VAL      1'h0
`define GBC_NIB_VAL      4'h0
`define GBC_BYTE_VAL     8'h00
`define GBC_HOT_NONE     4'h0

// Gain scaling: coefficient is Q.12, codes above GAIN_MAX fall back to unity
`define GBC_GAIN_MAX     4'hB
`define GBC_Q_SHIFT      12
`define GBC_COEF_0DB     16'h1000
`define GBC_COEF_1DB     16'h11F4
`define GBC_COEF_2DB     16'h1425
`define GBC_COEF_3DB     16'h169A
`define GBC_COEF_4DB     16'h195C
`define GBC_COEF_5DB     16'h1C74
`define GBC_COEF_6DB     16'h1FED
`define GBC_COEF_7DB     16'h23D2
`define GBC_COEF_8DB     16'h2831
`define GBC_COEF_9DB     16'h2D18
`define GBC_COEF_10DB    16'h3299
`define GBC_COEF_11DB    16'h38C5

// Saturation limits of a 14-bit signed sample
`define GBC_SAT_MAX      14'h1FFF
`define GBC_SAT_MIN      14'h2000
`define GBC_SAMP_ZERO    14'h0000

`endif

// [include/gbc_pkg.sv]
package gbc_pkg;

    typedef logic signed [13:0] gbc_samp_t;   // Converter sample
    typedef logic        [3:0]  gbc_gain_t;   // Gain step code
    typedef logic        [3:0]  gbc_band_t;   // Enable bit plus band code

    // Sampling bands for the analog correction loop
    typedef enum logic [2:0] {
        GBC_BAND_1ST,
        GBC_BAND_2ND,
        GBC_BAND_3RD,
        GBC_BAND_4TH
    } gbc_band_e;

endpackage : gbc_pkg

// [hw/gbc_gain.sv]
`timescale 1ns/10ps
`include "gbc_regs.svh"

module gbc_gain (
    input  wire logic              i_ref_clk, // Digital clock
    input  wire logic              i_rst_n,   // Synchronous reset, active low
    input  wire logic              i_clr,     // Core reset pulse
    input  wire gbc_pkg::gbc_gain_t i_gain,   // Gain step code
    input  wire logic              i_valid,   // Sample valid
    input  wire gbc_pkg::gbc_samp_t i_sample, // Sample in
    output logic                   o_valid,   // Scaled sample valid
    output gbc_pkg::gbc_samp_t     o_sample   // Scaled sample out
);

    logic signed [15:0] coef;        // Q.12 coefficient
    logic signed [29:0] product;     // Full product
    logic signed [17:0] scaled;      // Product after the shift
    gbc_pkg::gbc_samp_t sat;         // Saturated value
    logic               valid_reg;   // Output valid flop
    gbc_pkg::gbc_samp_t sample_reg;  // Output sample flop

    // Coefficient lookup; unsupported codes give unity so data never explodes
    always_comb begin
        unique case (i_gain)
            4'h1:    coef = `GBC_COEF_1DB;  // [RULE1]
            4'h2:    coef = `GBC_COEF_2DB;
            4'h3:    coef = `GBC_COEF_3DB;
            4'h4:    coef = `GBC_COEF_4DB;
            4'h5:    coef = `GBC_COEF_5DB;
            4'h6:    coef = `GBC_COEF_6DB;
            4'h7:    coef = `GBC_COEF_7DB;
            4'h8:    coef = `GBC_COEF_8DB;
            4'h9:    coef = `GBC_COEF_9DB;
            4'hA:    coef = `GBC_COEF_10DB;
            4'hB:    coef = `GBC_COEF_11DB; // [RULE1]
            default: coef = `GBC_COEF_0DB;
        endcase
    end

    // Scale and saturate; the signed 16-bit coefficient has room up to 16'h7FFF, about 18 dB
    assign product = i_sample * coef;                                 // [RULE1]
    assign scaled  = product[29:`GBC_Q_SHIFT];
    assign sat     = (scaled > $signed({4'h0, `GBC_SAT_MAX})) ? `GBC_SAT_MAX :
                     (scaled < $signed({4'hF, `GBC_SAT_MIN})) ? `GBC_SAT_MIN :
                     scaled[13:0];

    // Output stage, flushed by the core reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_clr) begin
            valid_reg  <= 1'b0;
            sample_reg <= `GBC_SAMP_ZERO;
        end else begin
            valid_reg  <= i_valid;
            sample_reg <= sat;
        end
    end

    assign o_valid  = valid_reg;
    assign o_sample = sample_reg;

    property p_unity_pass;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && !i_clr && i_gain == `GBC_NIB_VAL) |=> (o_sample == $past(i_sample));
    endproperty
    a_unity_pass: assert property (p_unity_pass) // [RULE1]
        else $error("Zero gain code altered the sample");

    property p_gain_max;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!i_clr && i_gain == `GBC_GAIN_MAX && i_sample == 14'h0100) |=> (o_sample == 14'h038C);
    endproperty
    a_gain_max: assert property (p_gain_max) // [RULE1]
        else $error("Top gain code did not give 11 dB");

endmodule : gbc_gain

// [hw/gbc_top.sv]
`timescale 1ns/10ps
`include "gbc_regs.svh"

// What this block does
// [RULE1] Scale samples by 0 to 11 dB steps
// [RULE2] Reset bit pulse 0-1-0 resets whole core
// [RULE3] Band settings apply only on core reset
// [RULE4] Band honoured only while enable bit set
// [RULE5] Software sets enable before band code
// [RULE6] Band codes 000 to 011 select bands 1-4
// [RULE7] Each channel has its own gain register
// [RULE8] Reserved bits ignored, read back as zero
module gbc_top (
    input  wire logic              i_ref_clk,   // Digital clock, 250 MHz
    input  wire logic              i_rst_n,     // Synchronous reset, active low
    input  wire logic              i_cfg_wr,    // Config write strobe
    input  wire logic              i_cfg_rd,    // Config read strobe
    input  wire logic [23:0]       i_cfg_page,  // Config page
    input  wire logic [11:0]       i_cfg_addr,  // Register address
    input  wire logic [7:0]        i_cfg_wdata, // Write data
    output logic      [7:0]        o_cfg_rdata, // Read data, registered
    input  wire logic              i_samp_vld,  // Sample valid, both channels
    input  wire gbc_pkg::gbc_samp_t i_samp_a,   // Channel A sample
    input  wire gbc_pkg::gbc_samp_t i_samp_b,   // Channel B sample
    output logic                   o_data_vld,  // Scaled data valid
    output gbc_pkg::gbc_samp_t     o_data_a,    // Channel A to downconverter
    output gbc_pkg::gbc_samp_t     o_data_b,    // Channel B to downconverter
    output logic                   o_core_rst,  // Core reset pulse, one cycle
    output logic      [3:0]        o_band_a,    // Channel A band, one-hot
    output logic      [3:0]        o_band_b     // Channel B band, one-hot
);

    logic               rst_bit_reg  [2];   // Stored reset bit per page
    gbc_pkg::gbc_band_t band_reg     [2];   // Written band fields
    gbc_pkg::gbc_band_t band_app_reg [2];   // Applied band fields
    gbc_pkg::gbc_gain_t gain_reg     [2];   // Gain code per channel
    logic [3:0]         band_hot     [2];   // Decoded band
    logic [7:0]         rd_part      [2];   // Read contribution per channel
    logic [1:0]         sel_rst;            // Reset register hit
    logic [1:0]         sel_band;           // Band register hit
    logic [1:0]         sel_gain;           // Gain register hit
    logic [1:0]         clear_evt;          // Falling edge of reset bit
    logic [1:0]         vld_ch;             // Per-channel valid
    gbc_pkg::gbc_samp_t samp_in  [2];       // Samples in
    gbc_pkg::gbc_samp_t samp_out [2];       // Samples out
    logic               core_rst_reg;       // Core reset pulse flop
    logic [7:0]         rdata_reg;          // Read data flop
    logic [7:0]         rdata_next;         // Read data next

    assign samp_in[0] = i_samp_a;
    assign samp_in[1] = i_samp_b;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            wire [23:0] main_pg = (ch == 0) ? `GBC_PG_MAIN_A : `GBC_PG_MAIN_B;
            wire [23:0] gain_pg = (ch == 0) ? `GBC_PG_GAIN_A : `GBC_PG_GAIN_B;

            // Page and address decode
            assign sel_rst[ch]  = (i_cfg_page == main_pg) && (i_cfg_addr == `GBC_ADR_RST);
            assign sel_band[ch] = (i_cfg_page == main_pg) && (i_cfg_addr == `GBC_ADR_BAND);
            assign sel_gain[ch] = (i_cfg_page == gain_pg)
                                  && (i_cfg_addr == `GBC_ADR_GAIN);              // [RULE7]

            // A 1 being cleared to 0 completes the 0-1-0 pulse
            assign clear_evt[ch] = i_cfg_wr && sel_rst[ch] && rst_bit_reg[ch]
                                   && !i_cfg_wdata[`GBC_RST_BIT];                // [RULE2]

            // Stored fields; reserved upper bits are simply not kept
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    rst_bit_reg[ch] <= `GBC_RST_VAL;
                    band_reg[ch]    <= `GBC_NIB_VAL;
                    gain_reg[ch]    <= `GBC_NIB_VAL;
                end else if (i_cfg_wr) begin
                    if (sel_rst[ch]) begin
                        rst_bit_reg[ch] <= i_cfg_wdata[`GBC_RST_BIT];
                    end
                    if (sel_band[ch]) begin
                        band_reg[ch] <= i_cfg_wdata[3:0];                        // [RULE8]
                    end
                    if (sel_gain[ch]) begin
                        gain_reg[ch] <= i_cfg_wdata[3:0];                        // [RULE7]
                    end
                end
            end

            // Applied copy follows the written one only on the core reset
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    band_app_reg[ch] <= `GBC_NIB_VAL;
                end else if (core_rst_reg) begin
                    band_app_reg[ch] <= band_reg[ch];                            // [RULE3]
                end
            end

            // Band decode, silent while the enable bit is clear or code is 1xx
            assign band_hot[ch] = !band_app_reg[ch][`GBC_BAND_EN_BIT] ? `GBC_HOT_NONE : // [RULE4]
                                  band_app_reg[ch][2] ? `GBC_HOT_NONE :
                                  (4'h1 << band_app_reg[ch][1:0]);               // [RULE6]

            // Readback of the stored fields, reserved bits as zero
            assign rd_part[ch] = (sel_rst[ch]  ? {7'h00, rst_bit_reg[ch]} : `GBC_BYTE_VAL)
                               | (sel_band[ch] ? {4'h0, band_reg[ch]}     : `GBC_BYTE_VAL)
                               | (sel_gain[ch] ? {4'h0, gain_reg[ch]} : `GBC_BYTE_VAL); // [RULE8]

            // Pre-downconverter gain of this channel only
            gbc_gain u_gain (
                .i_ref_clk (i_ref_clk),
                .i_rst_n   (i_rst_n),
                .i_clr     (core_rst_reg),
                .i_gain    (gain_reg[ch]),
                .i_valid   (i_samp_vld),
                .i_sample  (samp_in[ch]),
                .o_valid   (vld_ch[ch]),
                .o_sample  (samp_out[ch])
            );                                                                   // [RULE1]
        end
    endgenerate

    // Unmapped reads return zero
    assign rdata_next = rd_part[0] | rd_part[1];

    // Core reset pulse and read data; either page's bit resets both channels
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            core_rst_reg <= 1'b0;
            rdata_reg    <= `GBC_BYTE_VAL;
        end else begin
            core_rst_reg <= |clear_evt;                                          // [RULE2]
            if (i_cfg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign o_cfg_rdata = rdata_reg;
    assign o_core_rst  = core_rst_reg;
    // Both channels share one valid, so the merged flag only ever sees matching bits
    assign o_data_vld  = &vld_ch;
    assign o_data_a    = samp_out[0];
    assign o_data_b    = samp_out[1];
    assign o_band_a    = band_hot[0];
    assign o_band_b    = band_hot[1];

    property p_pulse_follows_clear;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (|clear_evt) |=> o_core_rst ##1 !o_core_rst || (|$past(clear_evt));
    endproperty
    a_pulse_follows_clear: assert property (p_pulse_follows_clear) // [RULE2]
        else $error("Core reset pulse missing after reset bit cleared");

    property p_pulse_has_cause;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_core_rst |-> $past(|clear_evt);
    endproperty
    a_pulse_has_cause: assert property (p_pulse_has_cause) // [RULE2]
        else $error("Core reset pulse without a 0-1-0 sequence");

    property p_band_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_core_rst |=> $stable(band_app_reg[0]) && $stable(band_app_reg[1]);
    endproperty
    a_band_hold: assert property (p_band_hold) // [RULE3]
        else $error("Applied band changed without core reset");

    property p_band_apply;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_core_rst |=> band_app_reg[1] == $past(band_reg[1]);
    endproperty
    a_band_apply: assert property (p_band_apply) // [RULE3]
        else $error("Written band not applied on core reset");

    property p_band_disabled;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !band_app_reg[0][`GBC_BAND_EN_BIT] |-> o_band_a == `GBC_HOT_NONE;
    endproperty
    a_band_disabled: assert property (p_band_disabled) // [RULE4]
        else $error("Band output active while enable clear");

    property p_band_decode;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (band_app_reg[1] == 4'hB) |-> o_band_b == 4'h8;
    endproperty
    a_band_decode: assert property (p_band_decode) // [RULE6]
        else $error("Code 011 did not select the fourth band");

    property p_gain_isolated;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cfg_wr && sel_gain[0]) |=> $stable(gain_reg[1])
            && gain_reg[0] == $past(i_cfg_wdata[3:0]);
    endproperty
    a_gain_isolated: assert property (p_gain_isolated) // [RULE7]
        else $error("Channel A gain write touched channel B");

    property p_reserved_zero;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_cfg_rd |=> o_cfg_rdata[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RULE8]
        else $error("Reserved read bits not zero");

endmodule : gbc_top

// [bench/gbc_tb.sv]
`timescale 1ns/10ps
`include "gbc_regs.svh"

module testbench;
    logic                i_ref_clk;   // 250 MHz clock
    logic                i_rst_n;     // Synchronous reset, active low
    logic                i_cfg_wr;    // Config write strobe
    logic                i_cfg_rd;    // Config read strobe
    logic [23:0]         i_cfg_page;  // Config page
    logic [11:0]         i_cfg_addr;  // Register address
    logic [7:0]          i_cfg_wdata; // Write data
    logic [7:0]          o_cfg_rdata; // Read data
    logic                i_samp_vld;  // Sample valid
    gbc_pkg::gbc_samp_t  i_samp_a;    // Channel A sample
    gbc_pkg::gbc_samp_t  i_samp_b;    // Channel B sample
    logic                o_data_vld;  // Scaled valid
    gbc_pkg::gbc_samp_t  o_data_a;    // Channel A scaled
    gbc_pkg::gbc_samp_t  o_data_b;    // Channel B scaled
    logic                o_core_rst;  // Core reset pulse
    logic [3:0]          o_band_a;    // Channel A band
    logic [3:0]          o_band_b;    // Channel B band
    int                  num_errors;  // Mismatch count
    int                  samples_checked; // Compare count
    int                  cycles;      // Watchdog count
    logic [15:0]         coef [12];   // Expected gain coefficients
    logic [23:0]         pgs [4];     // All pages
    logic [11:0]         adrs [3];    // All addresses
    logic [7:0]          bval [6];    // Band bytes to try
    logic [3:0]          bexp [6];    // Their one-hot result

    gbc_top i_gbc_top (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr),
        .i_cfg_rd(i_cfg_rd), .i_cfg_page(i_cfg_page), .i_cfg_addr(i_cfg_addr),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_samp_vld(i_samp_vld),
        .i_samp_a(i_samp_a), .i_samp_b(i_samp_b), .o_data_vld(o_data_vld),
        .o_data_a(o_data_a), .o_data_b(o_data_b), .o_core_rst(o_core_rst),
        .o_band_a(o_band_a), .o_band_b(o_band_b));

    // Free-running clock, 4 ns period
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    // Watchdog: the tests need well under a thousand cycles
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    // One compare; values widened so every field fits
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One write cycle; strobe drops at the next edge
    task automatic wr(input logic [23:0] pg, input logic [11:0] ad, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_cfg_wr    <= 1'b1;
        i_cfg_page  <= pg;
        i_cfg_addr  <= ad;
        i_cfg_wdata <= d;
        @(posedge i_ref_clk);
        i_cfg_wr    <= 1'b0;
    endtask : wr

    // One read cycle; data is registered one edge after the strobe
    task automatic rd(input logic [23:0] pg, input logic [11:0] ad, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_cfg_rd   <= 1'b1;
        i_cfg_page <= pg;
        i_cfg_addr <= ad;
        @(posedge i_ref_clk);
        i_cfg_rd   <= 1'b0;
        #1;
        check("read data", {8'h00, exp}, {8'h00, o_cfg_rdata});
    endtask : rd

    // Expected scaling: floor of Q.12 product, saturated to 14 bits
    function automatic logic [13:0] scale(input logic signed [13:0] s, input logic [15:0] c);
        logic signed [31:0] p;
        p = (s * $signed({1'b0, c})) >>> `GBC_Q_SHIFT;
        if (p > 32'sd8191) return `GBC_SAT_MAX;
        if (p < -32'sd8192) return `GBC_SAT_MIN;
        return p[13:0];
    endfunction : scale

    // One sample pair in, scaled pair checked a cycle later
    task automatic samp(input logic [13:0] a, input logic [13:0] b, input logic [3:0] ga,
                        input logic [3:0] gb);
        @(posedge i_ref_clk);
        i_samp_vld <= 1'b1;
        i_samp_a   <= a;
        i_samp_b   <= b;
        @(posedge i_ref_clk);
        i_samp_vld <= 1'b0;
        #1;
        check("data valid", 16'h0001, {15'h0000, o_data_vld});
        check("data a", {2'h0, scale(a, coef[ga])}, {2'h0, o_data_a});
        check("data b", {2'h0, scale(b, coef[gb])}, {2'h0, o_data_b});
    endtask : samp

    // The 0-1-0 sequence on a reset bit; pulse shows right after the final write
    task automatic pulse(input logic [23:0] pg);
        wr(pg, `GBC_ADR_RST, 8'h01);
        wr(pg, `GBC_ADR_RST, 8'h00);
        #1;
        check("core reset", 16'h0001, {15'h0000, o_core_rst});
        @(posedge i_ref_clk);
        #1;
        check("core reset end", 16'h0000, {15'h0000, o_core_rst});
        // Held inputs keep both outputs non-zero, so only the flush clears them here
        check("core flush a", 16'h0000, {2'h0, o_data_a});
        check("core flush b", 16'h0000, {2'h0, o_data_b});
    endtask : pulse

    // Verdict, printed from this one place only
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        {i_rst_n, i_cfg_wr, i_cfg_rd, i_samp_vld} = 4'h0;
        {i_cfg_page, i_cfg_addr, i_cfg_wdata} = 44'h0;
        {i_samp_a, i_samp_b} = 28'h0;
        {num_errors, samples_checked, cycles} = 0;
        coef = '{`GBC_COEF_0DB, `GBC_COEF_1DB, `GBC_COEF_2DB, `GBC_COEF_3DB,
                 `GBC_COEF_4DB, `GBC_COEF_5DB, `GBC_COEF_6DB, `GBC_COEF_7DB,
                 `GBC_COEF_8DB, `GBC_COEF_9DB, `GBC_COEF_10DB, `GBC_COEF_11DB};
        pgs  = '{`GBC_PG_GAIN_A, `GBC_PG_GAIN_B, `GBC_PG_MAIN_A, `GBC_PG_MAIN_B};
        adrs = '{`GBC_ADR_RST, `GBC_ADR_BAND, `GBC_ADR_GAIN};
        // Enable with codes 0-3, then enable off, then an unsupported code
        bval = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h01, 8'h0C};
        bexp = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0};
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;

        // Every page and address reads zero after reset, unmapped ones too
        foreach (pgs[p]) foreach (adrs[a]) rd(pgs[p], adrs[a], 8'h00);
        check("band a idle", 16'h0000, {12'h000, o_band_a});
        $display("Test reset values done");

        // Reserved bits are dropped; each channel keeps its own gain
        wr(`GBC_PG_GAIN_A, `GBC_ADR_GAIN, 8'hFF);
        wr(`GBC_PG_GAIN_B, `GBC_ADR_GAIN, 8'h05);
        wr(`GBC_PG_MAIN_A, `GBC_ADR_RST, 8'hFE);
        rd(`GBC_PG_GAIN_A, `GBC_ADR_GAIN, 8'h0F);
        rd(`GBC_PG_GAIN_B, `GBC_ADR_GAIN, 8'h05);
        rd(`GBC_PG_MAIN_A, `GBC_ADR_RST, 8'h00);
        $display("Test reserved bits done");

        // Every gain step on A, the mirror step on B, one negative input
        for (int g = 0; g < 12; g++) begin
            wr(`GBC_PG_GAIN_A, `GBC_ADR_GAIN, 8'(g));
            wr(`GBC_PG_GAIN_B, `GBC_ADR_GAIN, 8'(11 - g));
            samp(14'h0100, 14'h3EDD, 4'(g), 4'(11 - g));
        end
        // Full-scale inputs at top gain must saturate both ways
        wr(`GBC_PG_GAIN_B, `GBC_ADR_GAIN, 8'h0B);
        samp(14'h1FFF, 14'h2000, 4'hB, 4'hB);
        // An unsupported code falls back to unity gain
        wr(`GBC_PG_GAIN_A, `GBC_ADR_GAIN, 8'h0C);
        samp(14'h0100, 14'h2000, 4'h0, 4'hB);
        $display("Test gain steps done");

        // Bands apply only on the pulse; either page fires it for both
        for (int i = 0; i < 6; i++) begin
            wr(`GBC_PG_MAIN_A, `GBC_ADR_BAND, 8'h08);
            wr(`GBC_PG_MAIN_A, `GBC_ADR_BAND, bval[i]);
            wr(`GBC_PG_MAIN_B, `GBC_ADR_BAND, 8'h08);
            wr(`GBC_PG_MAIN_B, `GBC_ADR_BAND, bval[5 - i]);
            @(posedge i_ref_clk);
            #1;
            check("band a held", {12'h000, (i == 0) ? 4'h0 : bexp[i - 1]},
                  {12'h000, o_band_a});
            pulse((i % 2 == 0) ? `GBC_PG_MAIN_A : `GBC_PG_MAIN_B);
            check("band a", {12'h000, bexp[i]}, {12'h000, o_band_a});
            check("band b", {12'h000, bexp[5 - i]}, {12'h000, o_band_b});
        end
        $display("Test band select done");
        tally_and_finish();
    end
endmodule : testbench
